/* File: core/timer_out_flags.sv */
// The APB slave port was decided locally.
module timer_out_flags (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic presc_run_i,
  input wire logic counter_reload_i,
  input wire logic compare0_match_i,
  input wire logic compare1_match_i,
  input wire logic wrap_i,
  input wire logic capture0_i,
  input wire logic capture1_i,
  input wire logic dual_capture_mode_i,
  output logic prescaler_tick_o,
  output logic timer_output_a_o,
  output logic timer_output_b_o,
  output logic onchip_event_o,
  output logic capture_irq_o,
  output logic compare_irq_o,
  output logic wrap_irq_o,
  output logic sw_capture0_o,
  output logic sw_capture1_o
);
  timer_pkg::state_t st;
  timer_pkg::state_t next_st;
  logic setup;
  logic access;
  logic wr;
  logic [7:0] idx;
  logic mapped;
  logic [7:0] rd;
  logic flag_wr;
  logic sw0;
  logic sw1;
  logic [7:0] clr;
  logic [7:0] set;

  // Combined action of all events hitting one output this cycle
  function automatic logic act_level(input logic [7:0] ctl, input logic lvl,
                                     input logic e0, input logic e1, input logic ew);
    logic [1:0] a;
    begin
      a = timer_pkg::ACT_NOP;
      if (e0) begin
        a = a & ctl[timer_pkg::F_C0 +: 2];
      end
      if (e1) begin
        a = a & ctl[timer_pkg::F_C1 +: 2];
      end
      if (ew) begin
        a = a & ctl[timer_pkg::F_WRAP +: 2];
      end
      case (a)
        timer_pkg::ACT_SET: act_level = 1'b1;
        timer_pkg::ACT_TOGGLE: act_level = ~lvl;
        timer_pkg::ACT_RESET: act_level = 1'b0;
        default: act_level = lvl;
      endcase
    end
  endfunction

  always_comb begin
    next_st = st;
    setup = psel_i & ~penable_i;
    access = psel_i & penable_i & st.pready;
    wr = access & pwrite_i;
    idx = paddr_i[timer_pkg::ADDR_W-1:2];
    mapped = 1'b1;
    rd = 8'h00;
    case (idx)
      timer_pkg::IDX_DRIVE: rd = st.drive;
      timer_pkg::IDX_PRESET: rd = st.preset;
      timer_pkg::IDX_OUT_A: rd = st.ctl_a;
      timer_pkg::IDX_OUT_B: rd = st.ctl_b;
      timer_pkg::IDX_FLAGS: rd = st.flags;
      timer_pkg::IDX_MASK: rd = st.mask;
      default: mapped = 1'b0;
    endcase

    // Prescaler; a software or external reload restarts it from the preset
    next_st.tick = 1'b0;
    if (counter_reload_i) begin
      next_st.count = st.preset;
    end else if (presc_run_i) begin
      if (st.count == 8'h00) begin
        next_st.tick = 1'b1;
        next_st.count = st.preset;
      end else begin
        next_st.count = st.count - 8'h01;
      end
    end

    // Plain register writes
    if (wr) begin
      case (idx)
        timer_pkg::IDX_DRIVE: next_st.drive = pwdata_i[7:0] & timer_pkg::DRIVE_BITS;
        timer_pkg::IDX_PRESET: next_st.preset = pwdata_i[7:0];
        timer_pkg::IDX_OUT_A: next_st.ctl_a = pwdata_i[7:0];
        timer_pkg::IDX_OUT_B: next_st.ctl_b = pwdata_i[7:0];
        timer_pkg::IDX_MASK: next_st.mask = pwdata_i[7:0] & timer_pkg::MASK_BITS;
        default: ;
      endcase
    end

    // Hardware action overrides a software level written in the same cycle
    next_st.ctl_a[timer_pkg::F_LEVEL] = act_level(st.ctl_a,
        next_st.ctl_a[timer_pkg::F_LEVEL], compare0_match_i, compare1_match_i, wrap_i);
    next_st.ctl_b[timer_pkg::F_LEVEL] = act_level(st.ctl_b,
        next_st.ctl_b[timer_pkg::F_LEVEL], compare0_match_i, compare1_match_i, wrap_i);

    // Flags 7:1: zero clears, one is ignored except as a capture trigger; bit 0 takes the written value
    flag_wr = wr & (idx == timer_pkg::IDX_FLAGS);
    clr = flag_wr ? ~pwdata_i[7:0] : 8'h00;
    sw0 = flag_wr & pwdata_i[timer_pkg::FL_CP0] & ~st.flags[timer_pkg::FL_CP0];
    sw1 = flag_wr & pwdata_i[timer_pkg::FL_CP1] & ~st.flags[timer_pkg::FL_CP1]
          & ~dual_capture_mode_i;
    set = 8'h00;
    set[timer_pkg::FL_CP0] = capture0_i | sw0;
    set[timer_pkg::FL_CP1] = capture1_i | sw1;
    set[timer_pkg::FL_CM0] = compare0_match_i;
    set[timer_pkg::FL_CM1] = compare1_match_i;
    set[timer_pkg::FL_WRAP] = wrap_i;
    set[timer_pkg::FL_CAPTURE0_OVERRUN] = (capture0_i & st.flags[timer_pkg::FL_CP0]) | sw0;
    set[timer_pkg::FL_COMPARE0_OVERRUN] = compare0_match_i & st.flags[timer_pkg::FL_CM0];
    // Set wins over a clear in the same cycle
    next_st.flags[7:1] = set[7:1] | (st.flags[7:1] & ~clr[7:1]);
    if (flag_wr) begin
      next_st.flags[timer_pkg::FL_AND] = pwdata_i[timer_pkg::FL_AND];
    end
    next_st.sw_cap0 = sw0;
    next_st.sw_cap1 = sw1;

    // Interrupt requests follow the registered flag and mask values
    if (next_st.flags[timer_pkg::FL_AND]) begin
      next_st.cap_irq = next_st.flags[timer_pkg::FL_CP0] & next_st.mask[timer_pkg::MK_CP0]
          & next_st.flags[timer_pkg::FL_CP1] & next_st.mask[timer_pkg::MK_CP1];
    end else begin
      next_st.cap_irq = (next_st.flags[timer_pkg::FL_CP0] & next_st.mask[timer_pkg::MK_CP0])
          | (next_st.flags[timer_pkg::FL_CP1] & next_st.mask[timer_pkg::MK_CP1]);
    end
    next_st.cmp_irq = (next_st.flags[timer_pkg::FL_CM0] & next_st.mask[timer_pkg::MK_CM0])
        | (next_st.flags[timer_pkg::FL_CM1] & next_st.mask[timer_pkg::MK_CM1]);
    next_st.wrap_irq = next_st.flags[timer_pkg::FL_WRAP]
        & next_st.mask[timer_pkg::MK_WRAP];
    if (!next_st.mask[timer_pkg::MK_GT]) begin
      next_st.cap_irq = 1'b0;
      next_st.cmp_irq = 1'b0;
      next_st.wrap_irq = 1'b0;
    end

    next_st.pulse = (compare0_match_i & st.ctl_a[timer_pkg::F_PULSE])
        | (wrap_i & st.ctl_b[timer_pkg::F_PULSE]);

    // Disabled outputs idle high
    next_st.pin_a = next_st.drive[timer_pkg::DR_A] ?
        next_st.ctl_a[timer_pkg::F_LEVEL] : 1'b1;
    next_st.pin_b = next_st.drive[timer_pkg::DR_B] ?
        next_st.ctl_b[timer_pkg::F_LEVEL] : 1'b1;

    // No wait state: read data is latched in the setup cycle
    next_st.pready = setup;
    next_st.pslverr = setup & ~mapped;
    next_st.prdata = (setup & ~pwrite_i) ? {24'h000000, rd} : 32'h00000000;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.preset <= timer_pkg::RST_PRESET;
      st.count <= 8'h00;
      st.ctl_a <= timer_pkg::RST_CTL;
      st.ctl_b <= timer_pkg::RST_CTL;
      st.flags <= timer_pkg::RST_FLAGS;
      st.mask <= timer_pkg::RST_MASK;
      st.drive <= timer_pkg::RST_DRIVE;
      st.pin_a <= 1'b1;
      st.pin_b <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign pready_o = st.pready;
  assign prdata_o = st.prdata;
  assign pslverr_o = st.pslverr;
  assign prescaler_tick_o = st.tick;
  assign timer_output_a_o = st.pin_a;
  assign timer_output_b_o = st.pin_b;
  assign onchip_event_o = st.pulse;
  assign capture_irq_o = st.cap_irq;
  assign compare_irq_o = st.cmp_irq;
  assign wrap_irq_o = st.wrap_irq;
  assign sw_capture0_o = st.sw_cap0;
  assign sw_capture1_o = st.sw_cap1;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence lone_cmp0;
    ce_i && compare0_match_i && !compare1_match_i && !wrap_i;
  endsequence

  sequence cap0_sw_write;
    ce_i && flag_wr && pwdata_i[timer_pkg::FL_CP0] && !st.flags[timer_pkg::FL_CP0];
  endsequence

  chk_presc_reload: assert property (
    ce_i && counter_reload_i |=> st.count == $past(st.preset))
    else $error("prescaler did not reload from preset");

  chk_presc_underflow: assert property (
    ce_i && presc_run_i && !counter_reload_i && st.count == 8'h00
    |=> prescaler_tick_o && st.count == $past(st.preset))
    else $error("prescaler underflow missed");

  chk_toggle_a: assert property (
    lone_cmp0 ##0 (st.ctl_a[timer_pkg::F_C0 +: 2] == timer_pkg::ACT_TOGGLE)
    ##0 !(wr && idx == timer_pkg::IDX_OUT_A)
    |=> st.ctl_a[timer_pkg::F_LEVEL] != $past(st.ctl_a[timer_pkg::F_LEVEL]))
    else $error("output A toggle failed");

  chk_onchip_pulse: assert property (
    ce_i && compare0_match_i && st.ctl_a[timer_pkg::F_PULSE]
    |=> onchip_event_o ##1 (!onchip_event_o || $past(compare0_match_i || wrap_i)))
    else $error("on-chip event pulse wrong");

  chk_cap0_sw: assert property (
    cap0_sw_write |=> sw_capture0_o && st.flags[timer_pkg::FL_CAPTURE0_OVERRUN]
                      && st.flags[timer_pkg::FL_CP0])
    else $error("software capture 0 not handled");

  chk_cm0_overrun: assert property (
    ce_i && compare0_match_i && st.flags[timer_pkg::FL_CM0]
    |=> st.flags[timer_pkg::FL_COMPARE0_OVERRUN] && st.flags[timer_pkg::FL_CM0])
    else $error("compare 0 overrun not flagged");

  chk_wrap_flag: assert property (
    ce_i && wrap_i |=> st.flags[timer_pkg::FL_WRAP])
    else $error("wrap flag not set");

  chk_irq_global: assert property (
    !st.mask[timer_pkg::MK_GT] |-> !capture_irq_o && !compare_irq_o && !wrap_irq_o)
    else $error("interrupt passed with global enable clear");

  chk_pin_forced: assert property (
    !st.drive[timer_pkg::DR_A] |-> timer_output_a_o)
    else $error("disabled output A not high");

  chk_pin_follow: assert property (
    st.drive[timer_pkg::DR_B] |-> timer_output_b_o == st.ctl_b[timer_pkg::F_LEVEL])
    else $error("output B pin differs from level");

  chk_pin_forced_b: assert property (
    !st.drive[timer_pkg::DR_B] |-> timer_output_b_o)
    else $error("disabled output B not high");

  chk_presc_hold: assert property (
    ce_i && !presc_run_i && !counter_reload_i
    |=> st.count == $past(st.count) && !prescaler_tick_o)
    else $error("idle prescaler moved");

  chk_presc_step: assert property (
    ce_i && presc_run_i && !counter_reload_i && st.count != 8'h00
    |=> st.count == $past(st.count) - 8'h01 && !prescaler_tick_o)
    else $error("prescaler step wrong");

  chk_reload_no_tick: assert property (
    ce_i && counter_reload_i |=> !prescaler_tick_o)
    else $error("reload produced a tick");

  chk_preset_write: assert property (
    ce_i && wr && idx == timer_pkg::IDX_PRESET |=> st.preset == $past(pwdata_i[7:0]))
    else $error("preset write lost");

  chk_level_write: assert property (
    ce_i && wr && idx == timer_pkg::IDX_OUT_A && !compare0_match_i && !compare1_match_i
    && !wrap_i |=> st.ctl_a == $past(pwdata_i[7:0]))
    else $error("output A control write lost");

  chk_nop_hold: assert property (
    ce_i && !compare0_match_i && !compare1_match_i && !wrap_i
    && !(wr && idx == timer_pkg::IDX_OUT_B) |=> st.ctl_b == $past(st.ctl_b))
    else $error("output B control changed without cause");

  sequence wrap_alone;
    ce_i && wrap_i && !compare0_match_i && !compare1_match_i;
  endsequence

  chk_wrap_set_a: assert property (
    wrap_alone ##0 (st.ctl_a[timer_pkg::F_WRAP +: 2] == timer_pkg::ACT_SET)
    ##0 !(wr && idx == timer_pkg::IDX_OUT_A) |=> st.ctl_a[timer_pkg::F_LEVEL])
    else $error("output A set on wrap failed");

  chk_wrap_reset_b: assert property (
    wrap_alone ##0 (st.ctl_b[timer_pkg::F_WRAP +: 2] == timer_pkg::ACT_RESET)
    ##0 !(wr && idx == timer_pkg::IDX_OUT_B) |=> !st.ctl_b[timer_pkg::F_LEVEL])
    else $error("output B reset on wrap failed");

  chk_and_actions: assert property (
    ce_i && compare0_match_i && compare1_match_i && !wrap_i
    && st.ctl_a[timer_pkg::F_C0 +: 2] == timer_pkg::ACT_SET
    && st.ctl_a[timer_pkg::F_C1 +: 2] == timer_pkg::ACT_RESET
    && !(wr && idx == timer_pkg::IDX_OUT_A) |=> st.ctl_a[timer_pkg::F_LEVEL])
    else $error("combined action not ANDed");

  chk_wrap_pulse: assert property (
    ce_i && wrap_i && st.ctl_b[timer_pkg::F_PULSE] |=> onchip_event_o)
    else $error("wrap event pulse missing");

  chk_no_pulse: assert property (
    ce_i && !(compare0_match_i && st.ctl_a[timer_pkg::F_PULSE])
    && !(wrap_i && st.ctl_b[timer_pkg::F_PULSE]) |=> !onchip_event_o)
    else $error("event pulse without cause");

  chk_cap0_flag: assert property (
    ce_i && capture0_i |=> st.flags[timer_pkg::FL_CP0])
    else $error("capture 0 flag not set");

  chk_cap1_flag: assert property (
    ce_i && capture1_i |=> st.flags[timer_pkg::FL_CP1])
    else $error("capture 1 flag not set");

  chk_cmp0_flag: assert property (
    ce_i && compare0_match_i |=> st.flags[timer_pkg::FL_CM0])
    else $error("compare 0 flag not set");

  chk_cmp1_flag: assert property (
    ce_i && compare1_match_i |=> st.flags[timer_pkg::FL_CM1])
    else $error("compare 1 flag not set");

  chk_cap0_overrun: assert property (
    ce_i && capture0_i && st.flags[timer_pkg::FL_CP0] |=> st.flags[timer_pkg::FL_CAPTURE0_OVERRUN])
    else $error("capture 0 overrun not flagged");

  chk_cap1_dual: assert property (
    ce_i && flag_wr && dual_capture_mode_i && !capture1_i && !st.flags[timer_pkg::FL_CP1]
    |=> !sw_capture1_o && !st.flags[timer_pkg::FL_CP1])
    else $error("software capture 1 taken in dual mode");

  chk_wrap_clear: assert property (
    ce_i && flag_wr && !pwdata_i[timer_pkg::FL_WRAP] && !wrap_i
    |=> !st.flags[timer_pkg::FL_WRAP])
    else $error("wrap flag not cleared");

  chk_cm1_keep: assert property (
    ce_i && flag_wr && pwdata_i[timer_pkg::FL_CM1] && !compare1_match_i
    |=> st.flags[timer_pkg::FL_CM1] == $past(st.flags[timer_pkg::FL_CM1]))
    else $error("writing one changed compare 1 flag");

  chk_cmp0_irq: assert property (
    ce_i && compare0_match_i && st.mask[timer_pkg::MK_GT] && st.mask[timer_pkg::MK_CM0]
    && !(wr && idx == timer_pkg::IDX_MASK) |=> compare_irq_o)
    else $error("compare 0 interrupt missing");

  chk_cmp1_irq: assert property (
    ce_i && compare1_match_i && st.mask[timer_pkg::MK_GT] && st.mask[timer_pkg::MK_CM1]
    && !(wr && idx == timer_pkg::IDX_MASK) |=> compare_irq_o)
    else $error("compare 1 interrupt missing");

  chk_wrap_irq: assert property (
    ce_i && wrap_i && st.mask[timer_pkg::MK_GT] && st.mask[timer_pkg::MK_WRAP]
    && !(wr && idx == timer_pkg::IDX_MASK) |=> wrap_irq_o)
    else $error("wrap interrupt missing");

  chk_cap_irq_or: assert property (
    ce_i && capture0_i && !st.flags[timer_pkg::FL_AND] && st.mask[timer_pkg::MK_GT]
    && st.mask[timer_pkg::MK_CP0] && !(wr && idx == timer_pkg::IDX_MASK)
    && !flag_wr |=> capture_irq_o)
    else $error("capture interrupt missing in OR mode");

  chk_cap_irq_and: assert property (
    st.flags[timer_pkg::FL_AND] && capture_irq_o
    |-> st.flags[timer_pkg::FL_CP0] && st.flags[timer_pkg::FL_CP1])
    else $error("capture interrupt in AND mode with one flag");

  chk_apb_answer: assert property (
    ce_i && setup |=> pready_o && pslverr_o != $past(mapped))
    else $error("register bus answer wrong");
endmodule

/* File: pkg/timer_pkg.sv */
package timer_pkg;
  localparam int ADDR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DRIVE = 8'hf9;
  localparam logic [7:0] IDX_PRESET = 8'hfb;
  localparam logic [7:0] IDX_OUT_A = 8'hfc;
  localparam logic [7:0] IDX_OUT_B = 8'hfd;
  localparam logic [7:0] IDX_FLAGS = 8'hfe;
  localparam logic [7:0] IDX_MASK = 8'hff;
  // Output control fields
  localparam int F_C0 = 6;
  localparam int F_C1 = 4;
  localparam int F_WRAP = 2;
  localparam int F_PULSE = 1;
  localparam int F_LEVEL = 0;
  // Flag bank bits
  localparam int FL_CP0 = 7;
  localparam int FL_CP1 = 6;
  localparam int FL_CM0 = 5;
  localparam int FL_CM1 = 4;
  localparam int FL_WRAP = 3;
  localparam int FL_CAPTURE0_OVERRUN = 2;
  localparam int FL_COMPARE0_OVERRUN = 1;
  localparam int FL_AND = 0;
  // Mask bits
  localparam int MK_GT = 7;
  localparam int MK_CP0 = 5;
  localparam int MK_CP1 = 4;
  localparam int MK_CM0 = 2;
  localparam int MK_CM1 = 1;
  localparam int MK_WRAP = 0;
  localparam logic [7:0] MASK_BITS = 8'hb7;
  // Drive enable bits
  localparam int DR_B = 7;
  localparam int DR_A = 6;
  localparam logic [7:0] DRIVE_BITS = 8'hc0;
  // Reset values
  localparam logic [7:0] RST_PRESET = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  // Action codes, {bit1, bit0} of a field
  localparam logic [1:0] ACT_SET = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_RESET = 2'h2;
  localparam logic [1:0] ACT_NOP = 2'h3;

  typedef struct packed {
    logic [7:0] preset;
    logic [7:0] count;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] drive;
    logic pin_a;
    logic pin_b;
    logic tick;
    logic pulse;
    logic cap_irq;
    logic cmp_irq;
    logic wrap_irq;
    logic sw_cap0;
    logic sw_cap1;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;
endpackage

/* File: tb/timer_event_src.sv */
module timer_event_src (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic fire_i,
  input wire logic [4:0] pattern_i,
  output logic [4:0] events_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counter core gives single-cycle pulses; never held longer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      events_o <= 5'h00;
    end else begin
      events_o <= fire_i ? pattern_i : 5'h00;
    end
  end
endmodule

/* File: tb/timer_prescaler_output_flag_logic_bench.sv */
module timer_prescaler_output_flag_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, resetn_i, psel, penable, pwrite, presc_run, reload, dual, fire;
  logic pready, pslverr, tick, out_a, out_b, wrap_event_pulse_en, cirq, mirq, wirq, pa, pb, dm, rerr;
  logic sc0, sc1;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdata, rnd;
  logic [4:0] pat, ev;
  logic [7:0] ca, cb, fl, mk, d;
  logic [7:0] idxs [6];
  int errors, cmp_count, cycles, seed;

  timer_event_src i_src (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .fire_i(fire),
    .pattern_i(pat), .events_o(ev));
  timer_out_flags i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .presc_run_i(presc_run), .counter_reload_i(reload), .compare0_match_i(ev[0]),
    .compare1_match_i(ev[1]), .wrap_i(ev[2]), .capture0_i(ev[3]), .capture1_i(ev[4]),
    .dual_capture_mode_i(dual), .prescaler_tick_o(tick), .timer_output_a_o(out_a),
    .timer_output_b_o(out_b), .onchip_event_o(wrap_event_pulse_en), .capture_irq_o(cirq),
    .compare_irq_o(mirq), .wrap_irq_o(wirq), .sw_capture0_o(sc0), .sw_capture1_o(sc1));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    apb(1'b0, idx, 8'h00);
    chk(rdata, {24'h0, exp}, msg);
  endtask

  function automatic logic act(input logic [1:0] code, input logic p);
    case (code)
      2'h0: return 1'b1;
      2'h1: return ~p;
      2'h2: return 1'b0;
      default: return p;
    endcase
  endfunction

  task automatic measure(input int exp);
    int n;
    n = 0;
    do @(posedge ref_clk_i); while (tick !== 1'b1);
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (tick !== 1'b1);
    chk(n, exp, "tick spacing");
  endtask

  task automatic chk_irq;
    logic c0, c1;
    c0 = fl[7] & mk[5];
    c1 = fl[6] & mk[4];
    chk(cirq, mk[7] & (fl[0] ? c0 & c1 : c0 | c1), "capture irq");
    chk(mirq, mk[7] & ((fl[5] & mk[2]) | (fl[4] & mk[1])), "compare irq");
    chk(wirq, mk[7] & fl[3] & mk[0], "wrap irq");
  endtask

  task automatic wflags(input logic [7:0] wd);
    logic [7:0] n;
    logic e0, e1;
    e0 = wd[7] && !fl[7];
    e1 = wd[6] && !fl[6] && !dm;
    n = {fl[7:1] & wd[7:1], wd[0]};
    if (e0) begin
      n[7] = 1'b1;
      n[2] = 1'b1;
    end
    if (e1) begin
      n[6] = 1'b1;
    end
    fl = n;
    apb(1'b1, timer_pkg::IDX_FLAGS, wd);
    #1;
    chk({sc0, sc1}, {e0, e1}, "software capture pulse");
  endtask

  task automatic fire_ev(input logic [4:0] p);
    logic [1:0] ea, eb;
    ea = 2'h3;
    eb = 2'h3;
    if (p[0]) begin
      ea &= ca[7:6];
      eb &= cb[7:6];
    end
    if (p[1]) begin
      ea &= ca[5:4];
      eb &= cb[5:4];
    end
    if (p[2]) begin
      ea &= ca[3:2];
      eb &= cb[3:2];
    end
    pa = act(ea, pa);
    pb = act(eb, pb);
    if (p[3]) fl = fl | (fl[7] ? 8'h84 : 8'h80);
    if (p[0]) fl = fl | (fl[5] ? 8'h22 : 8'h20);
    fl = fl | {1'b0, p[4], 1'b0, p[1], p[2], 3'h0};
    @(posedge ref_clk_i);
    fire <= 1'b1;
    pat <= p;
    @(posedge ref_clk_i);
    fire <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk(out_a, pa, "output a");
    chk(out_b, pb, "output b");
    chk(wrap_event_pulse_en, (p[0] & ca[1]) | (p[2] & cb[1]), "event pulse");
    chk_irq();
  endtask

  initial begin
    seed = 33105;
    {psel, penable, pwrite, presc_run, reload, dual, fire, dm} = 8'h00;
    paddr = 10'h000;
    pwdata = 32'h0;
    pat = 5'h00;
    {ca, cb, fl, mk} = 32'h0;
    idxs = '{timer_pkg::IDX_DRIVE, timer_pkg::IDX_PRESET, timer_pkg::IDX_OUT_A,
      timer_pkg::IDX_OUT_B, timer_pkg::IDX_FLAGS, timer_pkg::IDX_MASK};
    resetn_i = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(idxs[i], 8'h00, "reset value");
    chk({out_a, out_b}, 2'h3, "pins while undriven");
    apb(1'b0, 8'h10, 8'h00);
    chk(rerr, 1'b1, "unmapped error flag");
    chk(rdata, 32'h00000000, "unmapped read data");
    presc_run <= 1'b1;
    measure(1);
    apb(1'b1, timer_pkg::IDX_PRESET, 8'h06);
    @(posedge ref_clk_i);
    reload <= 1'b1;
    @(posedge ref_clk_i);
    reload <= 1'b0;
    measure(7);
    apb(1'b1, timer_pkg::IDX_PRESET, 8'h02);
    measure(3);
    rd_chk(timer_pkg::IDX_PRESET, 8'h02, "preset");
    apb(1'b1, timer_pkg::IDX_DRIVE, 8'h40);
    #1;
    chk({out_a, out_b}, 2'h1, "only a driven");
    apb(1'b1, timer_pkg::IDX_DRIVE, 8'hc0);
    for (int i = 0; i < 40; i++) begin
      rnd = $random(seed);
      dm = rnd[8];
      dual <= dm;
      ca = rnd[7:0];
      pa = ca[0];
      apb(1'b1, timer_pkg::IDX_OUT_A, ca);
      cb = rnd[15:8];
      pb = cb[0];
      apb(1'b1, timer_pkg::IDX_OUT_B, cb);
      d = rnd[31:24];
      mk = (rnd[23:16] & timer_pkg::MASK_BITS) | (d[0] ? 8'h30 : 8'h00);
      wflags(d);
      apb(1'b1, timer_pkg::IDX_MASK, mk);
      rnd = $random(seed);
      fire_ev(rnd[4:0]);
      rd_chk(timer_pkg::IDX_OUT_A, {ca[7:1], pa}, "a readback");
      rd_chk(timer_pkg::IDX_OUT_B, {cb[7:1], pb}, "b readback");
      rd_chk(timer_pkg::IDX_FLAGS, fl, "flags");
      rd_chk(timer_pkg::IDX_MASK, mk, "mask");
    end
    complete_run();
  end
endmodule
